/* File: shared/fault_pkg.sv */
// Shared constants and carriers for the translation and numeric fault unit.
package fault_pkg;

   // Exception vectors.
   localparam logic [7:0] VEC_TRANSLATION = 8'h0e;
   localparam logic [7:0] VEC_NUMERIC     = 8'h10;

   // Translation fault error code bit positions.
   localparam int unsigned EC_PRESENT_BIT = 0;
   localparam int unsigned EC_WRITE_BIT   = 1;
   localparam int unsigned EC_USER_BIT    = 2;
   localparam int unsigned EC_RESERVED_BIT_VIOLATION_BIT    = 3;

   // Register byte offsets.
   localparam int unsigned REG_AW        = 8;
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_FAULT_ADR = 8'h04;
   localparam logic [7:0]  OFS_FAULT_CODE = 8'h08;
   localparam logic [7:0]  OFS_FP_MASK   = 8'h0c;
   localparam logic [7:0]  OFS_FP_STATUS = 8'h10;
   localparam logic [7:0]  OFS_FP_IP     = 8'h14;

   // Control register bit positions.
   localparam int unsigned CTRL_PAGING_BIT = 0;
   localparam int unsigned CTRL_NUMERR_BIT = 1;
   localparam int unsigned CTRL_LARGE_BIT  = 2;
   localparam int unsigned CTRL_EXTADR_BIT = 3;

   // Numeric error flags: stack, arith, zero divide, denormal, over, under, inexact.
   localparam int unsigned FP_FLAG_W          = 7;
   localparam logic [6:0]  FP_MASK_RESET      = 7'h7f;
   localparam int unsigned FP_STAT_PEND_BIT   = 7;

   // Numeric instruction classes.
   typedef enum logic [2:0] {
      FP_OP_WAITING = 3'b000,
      FP_OP_INIT_NW = 3'b001,
      FP_OP_CLEX_NW = 3'b010,
      FP_OP_STSW_NW = 3'b011,
      FP_OP_STCW_NW = 3'b100,
      FP_OP_ENV_NW  = 3'b101,
      FP_OP_SAVE_NW = 3'b110,
      FP_OP_WAIT    = 3'b111
   } fp_op_e;

   // Task switch stage of a translation.
   typedef enum logic [1:0] {
      TS_NONE     = 2'b00,
      TS_SAVE_OLD = 2'b01,
      TS_READ_GDT = 2'b10,
      TS_READ_NEW = 2'b11
   } task_stage_e;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        user;
      logic        dir_present;
      logic        dir_user;
      logic        dir_writable;
      logic        dir_reserved_bit_violation;
      logic        tbl_present;
      logic        tbl_user;
      logic        tbl_writable;
      task_stage_e stage;
      logic        after_commit;
      logic [31:0] linear_addr;
      logic [31:0] instr_ip;
      logic [31:0] new_task_ip;
   } xlat_req_s;

   typedef struct packed {
      logic   valid;
      fp_op_e kind;
      logic [31:0] ip;
   } fp_op_s;

   typedef struct packed {
      logic        valid;
      logic [6:0]  flags;
      logic [31:0] ip;
   } fp_err_s;

   typedef struct packed {
      logic        valid;
      logic [7:0]  vector;
      logic        has_code;
      logic [31:0] code;
      logic [31:0] saved_ip;
      logic        new_task_ctx;
      logic        load_new_state;
   } fault_rep_s;

   typedef struct packed {
      logic dir_accessed;
      logic dir_dirty;
      logic tbl_accessed;
      logic tbl_dirty;
   } pte_upd_s;

endpackage

/* File: hdl/fp_error_tracker.sv */
// Numeric error flags, pending state and waiting-instruction check.
module fp_error_tracker
   import fault_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic [6:0] mask,
   input  wire logic       ne_enable,
   // Instruction stream
   input  fault_pkg::fp_err_s err,
   input  fault_pkg::fp_op_s  op,
   // Results
   output logic [6:0]      flags,
   output logic [31:0]     err_ip,
   output logic            pending,
   output logic            use_default,
   output logic            raise
);

   typedef struct packed {
      logic [6:0]  flags;
      logic [31:0] err_ip;
      logic        pending;
   } trk_state_s;

   trk_state_s s_reg;
   trk_state_s s_next;
   logic       clr;
   logic [6:0] unmasked;

   function automatic logic is_nowait(input fp_op_e k);
      return (k != FP_OP_WAITING) && (k != FP_OP_WAIT);
   endfunction

   always_comb begin
      s_next   = s_reg;
      clr      = op.valid && (op.kind == FP_OP_INIT_NW || op.kind == FP_OP_CLEX_NW);
      unmasked = err.flags & ~mask;
      // Per-condition status flags; a new error beats a clear.
      s_next.flags = (clr ? '0 : s_reg.flags) | (err.valid ? err.flags : '0);
      s_next.pending = (s_reg.pending && !clr) || (err.valid && |unmasked && ne_enable);
      if (err.valid && |unmasked) begin
         s_next.err_ip = err.ip;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Masked error takes the default result.
   assign use_default = err.valid && |(err.flags & mask);
   // Raise on the next waiting instruction.
   assign raise   = op.valid && !is_nowait(op.kind) && s_reg.pending;
   assign flags   = s_reg.flags;
   assign err_ip  = s_reg.err_ip;
   assign pending = s_reg.pending;

endmodule // fp_error_tracker

/* File: hdl/page_fp_fault_unit.sv */
// Translation and numeric fault detection with an AHB-Lite register file.
//
// Behaviour
// - Vector 14 translation, 16 numeric; both faults.
// - Translation fault needs paging on, entry absent.
// - Privilege shortfall also raises translation fault.
// - Present bit: 0 absent, 1 rights/reserved.
// - Direction bit: 0 read, 1 write.
// - Privilege bit: 1 user, 0 supervisor.
// - Reserved-bit flag with large/extended enable set.
// - Fault address gets full linear address.
// - Protection fault sets directory accessed, dirty.
// - Table accessed only on write violation or fault-free access.
// - Saved pointer names the unexecuted faulting instruction.
// - New task reads fault in new context.
// - After commit load new state; before, none.
// - Numeric fault only if numeric enable set when the error occurs.
// - Seven numeric conditions, each flag and mask.
// - Masked error gives default result, continues.
// - Unmasked error pends until waiting instruction.
// - No-wait instructions skip the pending check.
// - Numeric fault pushes no error code.
// - Saved pointer waiting op; unit keeps producer.
module page_fp_fault_unit
   import fault_pkg::*;
(
   // Clock and reset
   input  wire logic          CLK_SYS,
   input  wire logic          RST_N,
   // AHB-Lite slave
   input  wire logic          HSEL,
   input  wire logic [31:0]   HADDR,
   input  wire logic [1:0]    HTRANS,
   input  wire logic          HWRITE,
   input  wire logic [2:0]    HSIZE,
   input  wire logic [31:0]   HWDATA,
   input  wire logic          HREADY,
   output logic [31:0]        HRDATA,
   output logic               HREADYOUT,
   output logic               HRESP,
   // Translation check
   input  fault_pkg::xlat_req_s XLAT_REQ,
   output fault_pkg::pte_upd_s  PTE_UPD,
   // Numeric unit
   input  fault_pkg::fp_op_s    FP_OP,
   input  fault_pkg::fp_err_s   FP_ERR,
   output logic                 FP_USE_DEFAULT,
   // Fault report
   output fault_pkg::fault_rep_s FAULT
);

   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic        paging_enable;
      logic        numeric_error_enable;
      logic        large_page_enable;
      logic        extended_address_enable;
      logic [6:0]  fp_mask;
      logic [31:0] fault_address_reg;
      logic [31:0] fault_code;
      fault_rep_s  fault;
      pte_upd_s    upd;
      logic        use_default;
   } top_state_s;

   localparam top_state_s ST_RESET = '{
      hreadyout: 1'b1,
      fp_mask:   FP_MASK_RESET,
      default:   '0
   };

   top_state_s s_reg;
   top_state_s s_next;

   // Numeric tracker results.
   logic [6:0]  fp_flags;
   logic [31:0] fp_err_ip;
   logic        fp_pending;
   logic        fp_use_default;
   logic        fp_raise;

   // Translation decode.
   logic        not_present;
   logic        priv_viol;
   logic        rw_viol;
   logic        reserved_bit_violation_viol;
   logic        xlat_fault;
   logic        bus_take;

   fp_error_tracker u_fp_tracker (
      .clk         (CLK_SYS),
      .rst_n       (RST_N),
      .mask        (s_reg.fp_mask),
      .ne_enable   (s_reg.numeric_error_enable),
      .err         (FP_ERR),
      .op          (FP_OP),
      .flags       (fp_flags),
      .err_ip      (fp_err_ip),
      .pending     (fp_pending),
      .use_default (fp_use_default),
      .raise       (fp_raise)
   );

   always_comb begin
      s_next = s_reg;
      s_next.fault = '0;
      s_next.upd = '0;
      s_next.use_default = fp_use_default;

      not_present = !XLAT_REQ.dir_present || !XLAT_REQ.tbl_present;
      priv_viol = XLAT_REQ.user && !(XLAT_REQ.dir_user && XLAT_REQ.tbl_user);
      rw_viol = XLAT_REQ.user && XLAT_REQ.write && !priv_viol
                && !(XLAT_REQ.dir_writable && XLAT_REQ.tbl_writable);
      // Reserved bits only count with an enable set.
      reserved_bit_violation_viol = XLAT_REQ.dir_present && XLAT_REQ.dir_reserved_bit_violation
                  && (s_reg.large_page_enable || s_reg.extended_address_enable);
      xlat_fault = s_reg.paging_enable && XLAT_REQ.valid
                   && (not_present || priv_viol || rw_viol || reserved_bit_violation_viol);

      if (xlat_fault) begin
         s_next.fault.valid = 1'b1;
         s_next.fault.vector = VEC_TRANSLATION;
         s_next.fault.has_code = 1'b1;
         s_next.fault.code[EC_PRESENT_BIT] = !not_present;
         s_next.fault.code[EC_WRITE_BIT] = XLAT_REQ.write;
         s_next.fault.code[EC_USER_BIT] = XLAT_REQ.user;
         s_next.fault.code[EC_RESERVED_BIT_VIOLATION_BIT] = reserved_bit_violation_viol;
         s_next.fault.saved_ip = XLAT_REQ.instr_ip;
         if (XLAT_REQ.stage == TS_READ_NEW) begin
            s_next.fault.saved_ip = XLAT_REQ.new_task_ip;
            s_next.fault.new_task_ctx = 1'b1;
         end
         // Load new state only after commit.
         s_next.fault.load_new_state = (XLAT_REQ.stage != TS_NONE)
                                       && XLAT_REQ.after_commit;
         s_next.fault_address_reg = XLAT_REQ.linear_addr;
         s_next.fault_code = s_next.fault.code;
      end else if (fp_raise) begin
         // Vector 16 at the waiting instruction.
         s_next.fault.valid = 1'b1;
         s_next.fault.vector = VEC_NUMERIC;
         s_next.fault.has_code = 1'b0;
         // Saved pointer is the waiting instruction.
         s_next.fault.saved_ip = FP_OP.ip;
      end

      // Entry flag updates follow the same translation attempt.
      if (s_reg.paging_enable && XLAT_REQ.valid && !not_present) begin
         if (priv_viol || rw_viol) begin
            // Directory flags set on protection fault.
            s_next.upd.dir_accessed = 1'b1;
            s_next.upd.dir_dirty = 1'b1;
            // Table accessed only for write violation.
            s_next.upd.tbl_accessed = rw_viol;
         end else if (!reserved_bit_violation_viol) begin
            // Clean access marks the table entry.
            s_next.upd.dir_accessed = 1'b1;
            s_next.upd.tbl_accessed = 1'b1;
            s_next.upd.tbl_dirty = XLAT_REQ.write;
         end
      end

      // Bus data phase of a write lands before any read decode below.
      if (s_reg.wr_pend) begin
         case (s_reg.wr_addr)
            OFS_CTRL: begin
               s_next.paging_enable = HWDATA[CTRL_PAGING_BIT];
               s_next.numeric_error_enable = HWDATA[CTRL_NUMERR_BIT];
               s_next.large_page_enable = HWDATA[CTRL_LARGE_BIT];
               s_next.extended_address_enable = HWDATA[CTRL_EXTADR_BIT];
            end
            OFS_FP_MASK: begin
               s_next.fp_mask = HWDATA[FP_FLAG_W-1:0];
            end
            default: begin
            end
         endcase
      end

      bus_take = HSEL && HTRANS[1] && HREADY;
      s_next.wr_pend = bus_take && HWRITE;
      if (bus_take) begin
         s_next.wr_addr = HADDR[REG_AW-1:0];
      end

      // Control, mask and fault reads see the freshest value, so a write just before is visible.
      if (bus_take && !HWRITE) begin
         s_next.hrdata = '0;
         case (HADDR[REG_AW-1:0])
            OFS_CTRL: begin
               s_next.hrdata[CTRL_PAGING_BIT] = s_next.paging_enable;
               s_next.hrdata[CTRL_NUMERR_BIT] = s_next.numeric_error_enable;
               s_next.hrdata[CTRL_LARGE_BIT] = s_next.large_page_enable;
               s_next.hrdata[CTRL_EXTADR_BIT] = s_next.extended_address_enable;
            end
            OFS_FAULT_ADR: begin
               s_next.hrdata = s_next.fault_address_reg;
            end
            OFS_FAULT_CODE: begin
               s_next.hrdata = s_next.fault_code;
            end
            OFS_FP_MASK: begin
               s_next.hrdata[FP_FLAG_W-1:0] = s_next.fp_mask;
            end
            OFS_FP_STATUS: begin
               s_next.hrdata[FP_FLAG_W-1:0] = fp_flags;
               s_next.hrdata[FP_STAT_PEND_BIT] = fp_pending;
            end
            OFS_FP_IP: begin
               s_next.hrdata = fp_err_ip;
            end
            default: begin
               s_next.hrdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         s_reg <= ST_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign HRDATA         = s_reg.hrdata;
   assign HREADYOUT      = s_reg.hreadyout;
   assign HRESP          = s_reg.hresp;
   assign PTE_UPD        = s_reg.upd;
   assign FP_USE_DEFAULT = s_reg.use_default;
   assign FAULT          = s_reg.fault;

endmodule // page_fp_fault_unit

/* File: sim/page_fp_fault_unit_sva.sv */
// Port-level assertion checker for the translation and numeric fault unit.
module page_fp_fault_unit_sva
   import fault_pkg::*;
(
   // Clock and reset
   input wire logic               CLK_SYS,
   input wire logic               RST_N,
   // Observed ports
   input wire logic               HREADYOUT,
   input wire logic               HRESP,
   input fault_pkg::xlat_req_s    XLAT_REQ,
   input fault_pkg::pte_upd_s     PTE_UPD,
   input fault_pkg::fp_op_s       FP_OP,
   input fault_pkg::fp_err_s      FP_ERR,
   input wire logic               FP_USE_DEFAULT,
   input fault_pkg::fault_rep_s   FAULT
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   logic xf;
   logic nf;
   assign xf = FAULT.valid && FAULT.vector == VEC_TRANSLATION;
   assign nf = FAULT.valid && FAULT.vector == VEC_NUMERIC;
   sequence xlat_sent;
      XLAT_REQ.valid;
   endsequence
   sequence xlat_faulted;
      xlat_sent ##1 xf;
   endsequence
   sequence wait_sent;
      FP_OP.valid && FP_OP.kind inside {FP_OP_WAITING, FP_OP_WAIT};
   endsequence
   bus_okay_a: assert property (HREADYOUT && !HRESP)
      else $error("bus not ready or error response");
   xlat_cause_a: assert property (xf |-> $past(XLAT_REQ.valid))
      else $error("translation fault without a request");
   code_bits_a: assert property (xlat_faulted |-> FAULT.has_code &&
      FAULT.code[31:4] == 28'h0 && FAULT.code[1] == $past(XLAT_REQ.write) &&
      FAULT.code[2] == $past(XLAT_REQ.user)) else $error("translation code bits wrong");
   present_bit_a: assert property (xlat_faulted |-> FAULT.code[0] ==
      ($past(XLAT_REQ.dir_present) && $past(XLAT_REQ.tbl_present)))
      else $error("present bit wrong");
   task_ctx_a: assert property (xlat_faulted |->
      FAULT.new_task_ctx == ($past(XLAT_REQ.stage) == TS_READ_NEW) && FAULT.saved_ip ==
      (FAULT.new_task_ctx ? $past(XLAT_REQ.new_task_ip) : $past(XLAT_REQ.instr_ip)))
      else $error("saved pointer or context wrong");
   commit_load_a: assert property (FAULT.load_new_state |-> xf &&
      $past(XLAT_REQ.after_commit) && $past(XLAT_REQ.stage) != TS_NONE)
      else $error("new state loaded without commit");
   absent_quiet_a: assert property (XLAT_REQ.valid &&
      !(XLAT_REQ.dir_present && XLAT_REQ.tbl_present) |=> PTE_UPD == '0)
      else $error("entry flags updated for absent entry");
   numeric_rep_a: assert property (wait_sent ##1 nf |-> !FAULT.has_code &&
      FAULT.code == 32'h0 && FAULT.saved_ip == $past(FP_OP.ip))
      else $error("numeric fault report wrong");
   numeric_cause_a: assert property (nf |-> $past(FP_OP.valid) &&
      $past(FP_OP.kind) inside {FP_OP_WAITING, FP_OP_WAIT})
      else $error("numeric fault on a no-wait op");
   default_cause_a: assert property (FP_USE_DEFAULT |-> $past(FP_ERR.valid))
      else $error("default result without an error");
   idle_quiet_a: assert property (!XLAT_REQ.valid && !FP_OP.valid |=>
      FAULT == '0 && PTE_UPD == '0) else $error("report without a cause");
endmodule // page_fp_fault_unit_sva

bind page_fp_fault_unit page_fp_fault_unit_sva chk_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
   .HREADYOUT(HREADYOUT), .HRESP(HRESP), .XLAT_REQ(XLAT_REQ), .PTE_UPD(PTE_UPD),
   .FP_OP(FP_OP), .FP_ERR(FP_ERR), .FP_USE_DEFAULT(FP_USE_DEFAULT), .FAULT(FAULT));

/* File: sim/tb_page_fp_fault_unit.sv */
// Self-checking testbench for the translation and numeric fault unit.
module tb_page_fp_fault_unit;
   timeunit 1ns;
   timeprecision 1ps;
   import fault_pkg::*;
   logic        CLK_SYS = 1'b0;
   logic        RST_N = 1'b0;
   logic        HSEL = 1'b0;
   logic        HWRITE = 1'b0;
   logic        HREADY;
   logic [31:0] HADDR = 32'h0;
   logic [31:0] HWDATA = 32'h0;
   logic [31:0] HRDATA;
   logic [1:0]  HTRANS = 2'h0;
   logic        HREADYOUT;
   logic        HRESP;
   logic        FP_USE_DEFAULT;
   xlat_req_s   XLAT_REQ = '0;
   pte_upd_s    PTE_UPD;
   fp_op_s      FP_OP = '0;
   fp_err_s     FP_ERR = '0;
   fault_rep_s  FAULT;
   int          miscompares = 0;
   int          comparisons = 0;
   logic [31:0] seed = 32'h17;
   logic [31:0] rd;
   logic [31:0] fa = 32'h0;
   logic [31:0] fc = 32'h0;
   logic [3:0]  ctl;
   assign HREADY = HREADYOUT;
   always #10 CLK_SYS = ~CLK_SYS;
   page_fp_fault_unit dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADY),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .XLAT_REQ(XLAT_REQ),
      .PTE_UPD(PTE_UPD), .FP_OP(FP_OP), .FP_ERR(FP_ERR), .FP_USE_DEFAULT(FP_USE_DEFAULT),
      .FAULT(FAULT));
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic conclude();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(string what, logic [127:0] exp, logic [127:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Any hang in the slave answer ends the run rather than stalling it.
   task automatic hwait();
      int n;
      n = 0;
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (HREADYOUT !== 1'b1 && n < 50);
      if (HREADYOUT !== 1'b1) begin
         miscompares++;
         conclude();
      end
   endtask
   task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge CLK_SYS);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= {24'h0, a};
      hwait();
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      hwait();
      rd = HRDATA;
   endtask
   task automatic xlat(xlat_req_s r);
      fault_rep_s f;
      pte_upd_s   p;
      logic np, pv, rw, rs;
      np = !(r.dir_present && r.tbl_present);
      pv = r.user && !(r.dir_user && r.tbl_user);
      rw = r.user && r.write && !pv && !(r.dir_writable && r.tbl_writable);
      rs = r.dir_present && r.dir_reserved_bit_violation && (ctl[2] || ctl[3]);
      f = '0;
      p = '0;
      if (ctl[0] && (np || pv || rw || rs)) begin
         f = '{1'b1, VEC_TRANSLATION, 1'b1, {28'h0, rs, r.user, r.write, !np},
               (r.stage == TS_READ_NEW) ? r.new_task_ip : r.instr_ip,
               r.stage == TS_READ_NEW, r.stage != TS_NONE && r.after_commit};
         fa = r.linear_addr;
         fc = f.code;
      end
      if (ctl[0] && !np) begin
         if (pv || rw)
            p = '{1'b1, 1'b1, rw, 1'b0};
         else if (!rs)
            p = '{1'b1, 1'b0, 1'b1, r.write};
      end
      @(posedge CLK_SYS);
      XLAT_REQ <= r;
      @(posedge CLK_SYS);
      XLAT_REQ <= '0;
      #1;
      chk("translation report", f, FAULT);
      chk("entry flags", p, PTE_UPD);
   endtask
   task automatic fperr(logic [6:0] fl, logic [31:0] ip, logic dflt);
      @(posedge CLK_SYS);
      FP_ERR <= '{1'b1, fl, ip};
      @(posedge CLK_SYS);
      FP_ERR <= '0;
      #1;
      chk("default result", dflt, FP_USE_DEFAULT);
   endtask
   task automatic fpop(fp_op_e k, logic pend);
      logic [31:0] ip;
      ip = rnd();
      @(posedge CLK_SYS);
      FP_OP <= '{1'b1, k, ip};
      @(posedge CLK_SYS);
      FP_OP <= '0;
      #1;
      chk("numeric report", pend ? {1'b1, VEC_NUMERIC, 1'b0, 32'h0, ip, 2'b0} : 76'h0, FAULT);
   endtask
   initial begin
      xlat_req_s   x;
      logic [31:0] w;
      logic [31:0] instruction_pointer;
      repeat (20) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      ahb(1'b0, OFS_FP_MASK, 32'h0);
      chk("mask reset", 32'h7f, rd);
      ahb(1'b0, 8'h40, 32'h0);
      chk("unmapped read", 32'h0, rd);
      for (int i = 0; i < 60; i++) begin
         w = rnd();
         ctl = w[3:0] & 4'hd;
         if (i < 3)
            ctl[0] = 1'b0;
         ahb(1'b1, OFS_CTRL, {28'h0, ctl});
         w = rnd();
         x = '{1'b1, w[0], w[1], w[2] | w[3], w[4], w[5] | w[6], w[7], w[8] | w[9], w[10],
               w[11] | w[12], task_stage_e'(w[14:13]), w[15], rnd(), rnd(), rnd()};
         xlat(x);
         ahb(1'b0, OFS_FAULT_ADR, 32'h0);
         chk("fault address", fa, rd);
         ahb(1'b0, OFS_FAULT_CODE, 32'h0);
         chk("fault code", fc, rd);
      end
      // A write to the read-only address register must leave it alone.
      ahb(1'b1, OFS_FAULT_ADR, ~fa);
      ahb(1'b0, OFS_FAULT_ADR, 32'h0);
      chk("fault address kept", fa, rd);
      ahb(1'b1, OFS_CTRL, 32'h2);
      for (int i = 0; i < 7; i++) begin
         ahb(1'b1, OFS_FP_MASK, {25'h0, 7'h7f ^ (7'h1 << i)});
         fperr(7'h7f ^ (7'h1 << i), rnd(), 1'b1);
         fpop(FP_OP_WAITING, 1'b0);
         instruction_pointer = rnd();
         fperr(7'h1 << i, instruction_pointer, 1'b0);
         fpop(fp_op_e'(3 + i % 4), 1'b0);
         fpop(FP_OP_WAITING, 1'b1);
         fpop(FP_OP_WAIT, 1'b1);
         ahb(1'b0, OFS_FP_IP, 32'h0);
         chk("error pointer", instruction_pointer, rd);
         ahb(1'b0, OFS_FP_STATUS, 32'h0);
         chk("numeric status", 32'hff, rd);
         fpop(i[0] ? FP_OP_CLEX_NW : FP_OP_INIT_NW, 1'b0);
         fpop(FP_OP_WAIT, 1'b0);
      end
      ahb(1'b1, OFS_CTRL, 32'h1);
      ahb(1'b1, OFS_FP_MASK, 32'h0);
      fperr(7'h04, rnd(), 1'b0);
      fpop(FP_OP_WAITING, 1'b0);
      ahb(1'b0, OFS_CTRL, 32'h0);
      chk("control readback", 32'h1, rd);
      conclude();
   end
endmodule // tb_page_fp_fault_unit
